// ==== verilog/bertm_pkg.sv ====
// Constants, types and shared pattern function for the BER monitor and test modes
// Notes on behaviour
// - Lock output is high while synchronised to the pattern, low once sync is lost.
// - Elapsed time starts at zero on test start or restart and runs meanwhile.
// - Each drop out of lock on 16 errors in a window adds one to the lock-loss count; disable or restart does not.
// - Count every received bit while locked that differs from the expected pattern; error counting stops once the bit count saturates.
// - Count received bits while locked; ratio is error count divided by that bit count.
// - Inject request inverts exactly one outgoing pattern bit.
// - Restart clears all counts and returns the checker to its initial state.
// - Carrier mode sends an unmodulated carrier; off after reset.
// - Alternate mode feeds 1,0,1,0 per symbol in place of traffic; off after reset.
// - Wide capture sets a four-times span and blocks demodulator lock; off by default.
// - Transmit tone replaces satellite-bound audio in both channels.
// - Receive tone replaces terrestrial-bound audio in both channels.
// - Both tone enables toggle independently and are off after reset.
// - Selectable fixed, alternating and pseudo-random patterns; default 20-stage sequence.
package bertm_pkg;
    localparam int          CLK_PERIOD_NS    = 4;
    localparam int          TICK_MS          = 1;
    localparam int          TICK_CYCLES      = TICK_MS * 1000000 / CLK_PERIOD_NS;
    localparam int          TONE_FREQ_HZ     = 1000;
    localparam int          TONE_HALF_CYCLES = 1000000000 / (CLK_PERIOD_NS * TONE_FREQ_HZ * 2);
    localparam int          HIST_W           = 23;
    localparam logic [5:0]  SYNC_MATCH_LAST  = 6'h1f;
    localparam logic [5:0]  WIN_LAST         = 6'h3f;
    localparam logic [6:0]  LOSS_ERRS        = 7'h10;
    localparam logic [5:0]  DIV_STEPS        = 6'h20;
    localparam logic [15:0] TONE_AMPL        = 16'h4000;
    localparam logic [15:0] TONE_LOW         = 16'hc000;
    localparam logic [HIST_W-1:0] HIST_SEED  = 23'h7fffff;

    typedef enum logic [3:0] {
        PAT_ALT10, PAT_ALL1, PAT_ALL0, PAT_PRBS20, PAT_PRBS15, PAT_PRBS11,
        PAT_PRBS23, PAT_PRBS9, PAT_PRBS7, PAT_PRBS6
    } bertm_pat_type;

    typedef enum {S_IDLE, S_HUNT, S_LOCK} bertm_lock_type;

    // Next bit from the bit history; used by both generator and checker
    function automatic logic bertm_predict(input logic [HIST_W-1:0] h, input bertm_pat_type p);
        case (p)
            PAT_ALT10:  bertm_predict = ~h[0];
            PAT_ALL1:   bertm_predict = 1'b1;
            PAT_ALL0:   bertm_predict = 1'b0;
            PAT_PRBS15: bertm_predict = h[14] ^ h[13];
            PAT_PRBS11: bertm_predict = h[10] ^ h[8];
            PAT_PRBS23: bertm_predict = h[22] ^ h[17];
            PAT_PRBS9:  bertm_predict = h[8] ^ h[4];
            PAT_PRBS7:  bertm_predict = h[6] ^ h[5];
            PAT_PRBS6:  bertm_predict = h[5] ^ h[4];
            default:    bertm_predict = h[19] ^ h[2];
        endcase
    endfunction : bertm_predict
endpackage : bertm_pkg

// ==== verilog/bertm_gen_if.sv ====
// Link between the monitor core and the pattern generator
`timescale 1ns/10ps
`default_nettype none
interface bertm_gen_if;
    import bertm_pkg::*;
    logic          step;
    logic          inject;
    logic          restart;
    bertm_pat_type pat;
    logic          bit_out;
    modport ctl (output step, inject, restart, pat, input bit_out);
    modport gen (input step, inject, restart, pat, output bit_out);
endinterface : bertm_gen_if
`default_nettype wire

// ==== verilog/bertm_pat_gen.sv ====
// Transmit test pattern generator with single-bit error injection
`timescale 1ns/10ps
`default_nettype none
module bertm_pat_gen import bertm_pkg::*; (
    input  wire logic i_ref_clk,
    input  wire logic i_rst,
    bertm_gen_if.gen  g
);
    typedef struct packed {
        logic [HIST_W-1:0] hist;
        logic              pend;
    } bertm_gen_st_type;

    bertm_gen_st_type st;
    bertm_gen_st_type next_st;
    logic             nb;

    // Bit offered now; advances only on step so the caller can register it
    always_comb begin
        next_st = st;
        nb = bertm_predict(st.hist, g.pat);
        g.bit_out = nb ^ (st.pend | g.inject);
        if (g.step) begin
            next_st.hist = {st.hist[HIST_W-2:0], nb};
            next_st.pend = 1'b0;
        end else if (g.inject) begin
            next_st.pend = 1'b1;
        end
        if (g.restart) begin
            next_st.hist = HIST_SEED;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            // No error may be pending out of reset, or the first stepped bit would flip
            st <= '{hist: HIST_SEED, pend: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    a_inject_one_bit: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        g.step |=> !st.pend)
        else $error("inject flipped more than one bit");
    a_inject_held: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (g.inject && !g.step) |=> st.pend)
        else $error("inject request was lost");
endmodule : bertm_pat_gen
`default_nettype wire

// ==== verilog/bertm_tone_gen.sv ====
// Square test tone for the audio channels
`timescale 1ns/10ps
`default_nettype none
module bertm_tone_gen import bertm_pkg::*; #(
    parameter int P_HALF_CYCLES = TONE_HALF_CYCLES
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    input  wire logic        i_enable,
    output logic      [15:0] o_sample
);
    typedef struct packed {
        logic [23:0] cnt;
        logic        high;
    } bertm_tone_st_type;

    bertm_tone_st_type st;
    bertm_tone_st_type next_st;

    // Square wave keeps the core tiny; a filter downstream smooths it if needed
    always_comb begin
        next_st = st;
        if (!i_enable) begin
            next_st = '0;
        end else if (st.cnt == 24'(P_HALF_CYCLES - 1)) begin
            next_st.cnt  = '0;
            next_st.high = ~st.high;
        end else begin
            next_st.cnt = st.cnt + 24'h1;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_sample = st.high ? TONE_AMPL : TONE_LOW;
endmodule : bertm_tone_gen
`default_nettype wire

// ==== verilog/bertm_monitor.sv ====
// BER monitor, pattern checker and transmit test-mode control
`timescale 1ns/10ps
`default_nettype none
module bertm_monitor import bertm_pkg::*; #(
    parameter int P_TICK_CYCLES = TICK_CYCLES,
    parameter int P_TONE_HALF   = TONE_HALF_CYCLES
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    input  wire logic        i_bert_enable,
    input  wire logic        i_restart,
    input  wire logic        i_inject,
    input  wire logic        i_pattern_load,
    input  wire logic [3:0]  i_pattern_sel,
    input  wire logic        i_rx_bit,
    input  wire logic        i_rx_bit_en,
    input  wire logic        i_tx_data,
    input  wire logic        i_tx_data_en,
    input  wire logic        i_sym_en,
    input  wire logic        i_carrier_mode,
    input  wire logic        i_alt_mode,
    input  wire logic        i_wide_mode,
    input  wire logic        i_tx_tone_on,
    input  wire logic        i_tx_tone_off,
    input  wire logic        i_rx_tone_on,
    input  wire logic        i_rx_tone_off,
    input  wire logic [15:0] i_tx_aud_l,
    input  wire logic [15:0] i_tx_aud_r,
    input  wire logic [15:0] i_rx_aud_l,
    input  wire logic [15:0] i_rx_aud_r,
    output logic             o_sync_lock,
    output logic      [31:0] o_elapsed_ms,
    output logic      [15:0] o_loss_count,
    output logic      [31:0] o_error_count,
    output logic      [31:0] o_bit_count,
    output logic      [31:0] o_ber_ratio,
    output logic             o_mod_bit,
    output logic             o_unmodulated_carrier_mode,
    output logic             o_demod_span_x4,
    output logic             o_demod_lock_inhibit,
    output logic             o_tx_tone_active,
    output logic             o_rx_tone_active,
    output logic      [15:0] o_tx_aud_l,
    output logic      [15:0] o_tx_aud_r,
    output logic      [15:0] o_rx_aud_l,
    output logic      [15:0] o_rx_aud_r
);
    typedef struct packed {
        bertm_lock_type    state;
        logic              lock;
        logic [HIST_W-1:0] hist;
        logic [5:0]        match_cnt;
        logic [5:0]        win_cnt;
        logic [6:0]        win_err;
        logic [31:0]       errors;
        logic [31:0]       bits;
        logic [15:0]       loss;
        logic [23:0]       tick_cnt;
        logic [31:0]       time_ms;
        logic [32:0]       div_rem;
        logic [31:0]       div_den;
        logic [31:0]       div_q;
        logic [5:0]        div_cnt;
        logic [31:0]       ratio;
        logic              on_d;
        bertm_pat_type     pat;
        logic              cw;
        logic              wide;
        logic              tx_tone;
        logic              rx_tone;
        logic              mod_bit;
        logic [15:0]       tx_l;
        logic [15:0]       tx_r;
        logic [15:0]       rx_l;
        logic [15:0]       rx_r;
    } bertm_top_st_type;

    bertm_top_st_type st;
    bertm_top_st_type next_st;
    logic             rx_pred;
    logic             rx_err;
    logic             start;
    logic             clear;
    logic             tick;
    logic             bits_sat;
    logic [6:0]       win_err_n;
    logic [32:0]      div_t;
    logic [15:0]      tone_smp;

    bertm_gen_if gen_link ();

    bertm_pat_gen u_gen (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .g         (gen_link.gen)
    );

    bertm_tone_gen #(.P_HALF_CYCLES(P_TONE_HALF)) u_tone (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_enable  (st.tx_tone | st.rx_tone),
        .o_sample  (tone_smp)
    );

    // Generator steps only when its bit actually reaches the modulator
    assign gen_link.step    = i_tx_data_en & i_bert_enable & ~i_carrier_mode & ~i_alt_mode;
    assign gen_link.inject  = i_inject;
    assign gen_link.restart = i_restart;
    assign gen_link.pat     = st.pat;

    always_comb begin
        next_st   = st;
        rx_pred   = bertm_predict(st.hist, st.pat);
        rx_err    = i_rx_bit ^ rx_pred;
        start     = i_bert_enable & ~st.on_d;
        clear     = start | i_restart;
        tick      = st.tick_cnt == 24'(P_TICK_CYCLES - 1);
        bits_sat  = &st.bits;
        win_err_n = st.win_err + {6'h0, rx_err};
        div_t     = {st.div_rem[31:0], 1'b0};
        next_st.on_d = i_bert_enable;

        if (i_pattern_load) begin
            next_st.pat = bertm_pat_type'(i_pattern_sel);
        end
        next_st.cw   = i_carrier_mode;
        next_st.wide = i_wide_mode;
        if (i_tx_tone_on) begin
            next_st.tx_tone = 1'b1;
        end else if (i_tx_tone_off) begin
            next_st.tx_tone = 1'b0;
        end
        if (i_rx_tone_on) begin
            next_st.rx_tone = 1'b1;
        end else if (i_rx_tone_off) begin
            next_st.rx_tone = 1'b0;
        end

        // Elapsed time holds its last value once the test is switched off
        if (!i_bert_enable) begin
            next_st.tick_cnt = '0;
        end else if (tick) begin
            next_st.tick_cnt = '0;
            next_st.time_ms  = st.time_ms + 32'h1;
        end else begin
            next_st.tick_cnt = st.tick_cnt + 24'h1;
        end

        case (st.state)
            S_IDLE: begin
                next_st.match_cnt = '0;
                if (i_bert_enable) begin
                    next_st.state = S_HUNT;
                end
            end
            S_HUNT: begin
                if (i_rx_bit_en) begin
                    next_st.hist = {st.hist[HIST_W-2:0], i_rx_bit};
                    if (rx_err) begin
                        next_st.match_cnt = '0;
                    end else if (st.match_cnt == SYNC_MATCH_LAST) begin
                        next_st.state   = S_LOCK;
                        next_st.win_cnt = '0;
                        next_st.win_err = '0;
                    end else begin
                        next_st.match_cnt = st.match_cnt + 6'h1;
                    end
                end
            end
            S_LOCK: begin
                if (i_rx_bit_en) begin
                    // Flywheel on the prediction so one bad bit costs one error, not three
                    next_st.hist = {st.hist[HIST_W-2:0], rx_pred};
                    if (!bits_sat) begin
                        next_st.bits   = st.bits + 32'h1;
                        next_st.errors = st.errors + {31'h0, rx_err};
                    end
                    if (win_err_n == LOSS_ERRS) begin
                        next_st.state     = S_HUNT;
                        next_st.loss      = st.loss + 16'h1;
                        next_st.match_cnt = '0;
                    end else if (st.win_cnt == WIN_LAST) begin
                        next_st.win_cnt = '0;
                        next_st.win_err = '0;
                    end else begin
                        next_st.win_cnt = st.win_cnt + 6'h1;
                        next_st.win_err = win_err_n;
                    end
                end
            end
            default: begin
                next_st.state = S_IDLE;
            end
        endcase
        if (!i_bert_enable) begin
            next_st.state = S_IDLE;
        end

        // Ratio is a 32-bit binary fraction refreshed every 33 cycles
        if (st.div_cnt == 6'h0) begin
            if (st.bits == 32'h0) begin
                next_st.ratio = '0;
            end else begin
                next_st.div_rem = {1'b0, st.errors};
                next_st.div_den = st.bits;
                next_st.div_q   = '0;
                next_st.div_cnt = DIV_STEPS;
            end
        end else begin
            if (div_t >= {1'b0, st.div_den}) begin
                next_st.div_rem = div_t - {1'b0, st.div_den};
                next_st.div_q   = {st.div_q[30:0], 1'b1};
            end else begin
                next_st.div_rem = div_t;
                next_st.div_q   = {st.div_q[30:0], 1'b0};
            end
            next_st.div_cnt = st.div_cnt - 6'h1;
            if (st.div_cnt == 6'h1) begin
                next_st.ratio = next_st.div_q;
            end
        end

        if (clear) begin
            next_st.state     = S_IDLE;
            next_st.match_cnt = '0;
            next_st.errors    = '0;
            next_st.bits      = '0;
            next_st.loss      = '0;
            next_st.time_ms   = '0;
            next_st.tick_cnt  = '0;
            next_st.div_cnt   = '0;
            next_st.ratio     = '0;
        end
        next_st.lock = next_st.state == S_LOCK;

        // Carrier beats alternate, which beats test pattern and traffic
        if (i_carrier_mode) begin
            next_st.mod_bit = 1'b0;
        end else if (i_alt_mode) begin
            if (i_sym_en) begin
                next_st.mod_bit = ~st.mod_bit;
            end
        end else if (i_tx_data_en) begin
            next_st.mod_bit = i_bert_enable ? gen_link.bit_out : i_tx_data;
        end

        next_st.tx_l = st.tx_tone ? tone_smp : i_tx_aud_l;
        next_st.tx_r = st.tx_tone ? tone_smp : i_tx_aud_r;
        next_st.rx_l = st.rx_tone ? tone_smp : i_rx_aud_l;
        next_st.rx_r = st.rx_tone ? tone_smp : i_rx_aud_r;
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            st     <= '0;
            st.pat <= PAT_PRBS20;
        end else begin
            st <= next_st;
        end
    end

    assign o_sync_lock                = st.lock;
    assign o_elapsed_ms               = st.time_ms;
    assign o_loss_count               = st.loss;
    assign o_error_count              = st.errors;
    assign o_bit_count                = st.bits;
    assign o_ber_ratio                = st.ratio;
    assign o_mod_bit                  = st.mod_bit;
    assign o_unmodulated_carrier_mode = st.cw;
    assign o_demod_span_x4            = st.wide;
    assign o_demod_lock_inhibit       = st.wide;
    assign o_tx_tone_active           = st.tx_tone;
    assign o_rx_tone_active           = st.rx_tone;
    assign o_tx_aud_l                 = st.tx_l;
    assign o_tx_aud_r                 = st.tx_r;
    assign o_rx_aud_l                 = st.rx_l;
    assign o_rx_aud_r                 = st.rx_r;

    a_lock_from_hunt: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        $rose(o_sync_lock) |-> $past(st.state) == S_HUNT && $past(st.match_cnt) == SYNC_MATCH_LAST)
        else $error("lock rose without a full run of matches");
    a_time_advance: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (tick && i_bert_enable && !clear) |=> o_elapsed_ms == $past(o_elapsed_ms) + 32'h1)
        else $error("elapsed time missed a tick");
    a_loss_count_step: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (o_sync_lock && !next_st.lock && i_bert_enable && !clear)
        |=> o_loss_count == $past(o_loss_count) + 16'h1)
        else $error("lock loss not counted");
    a_error_count_step: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (st.state == S_LOCK && i_rx_bit_en && rx_err && !bits_sat && !clear)
        |=> o_error_count == $past(o_error_count) + 32'h1 && o_bit_count == $past(o_bit_count) + 32'h1)
        else $error("bit error not counted");
    a_ratio_zero_bits: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        o_bit_count == 32'h0 |-> o_ber_ratio == 32'h0)
        else $error("ratio nonzero with no bits counted");
    a_restart_clears: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_restart |=> o_error_count == 32'h0 && o_loss_count == 16'h0 && o_elapsed_ms == 32'h0
        && !o_sync_lock && o_bit_count == 32'h0)
        else $error("restart left counts standing");
    a_carrier_mode: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_carrier_mode |=> o_unmodulated_carrier_mode && !o_mod_bit)
        else $error("carrier mode still modulating");
    a_alt_toggle: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_alt_mode && !i_carrier_mode && i_sym_en) |=> o_mod_bit != $past(o_mod_bit))
        else $error("alternate pattern did not toggle on symbol");
    a_wide_mode: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_wide_mode |=> o_demod_span_x4 && o_demod_lock_inhibit)
        else $error("wide capture not applied");
    a_tx_tone_out: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        st.tx_tone |=> o_tx_aud_l == $past(tone_smp) && o_tx_aud_r == $past(tone_smp))
        else $error("transmit tone not on both channels");
    a_rx_tone_out: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        st.rx_tone |=> o_rx_aud_l == $past(tone_smp) && o_rx_aud_r == $past(tone_smp))
        else $error("receive tone not on both channels");
    a_tone_toggle: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_tx_tone_off && !i_tx_tone_on && !i_rx_tone_on && !i_rx_tone_off)
        |=> !o_tx_tone_active && o_rx_tone_active == $past(o_rx_tone_active))
        else $error("tone enables not independent");
endmodule : bertm_monitor
`default_nettype wire

// ==== test/bertm_far_end.sv ====
// Far-end model: sends the 20-stage test sequence or loops the modulator bit back
`timescale 1ns/10ps
`default_nettype none
module bertm_far_end (
    input  wire logic i_ref_clk,
    input  wire logic i_rst,
    input  wire logic i_run,
    input  wire logic i_loop,
    input  wire logic i_flip,
    input  wire logic i_loop_bit,
    output logic      o_rx_bit,
    output logic      o_rx_bit_en
);
    logic [19:0] hist;
    logic        nb;
    assign nb = hist[19] ^ hist[2];
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            hist        <= 20'hfffff;
            o_rx_bit    <= 1'b0;
            o_rx_bit_en <= 1'b0;
        end else begin
            o_rx_bit_en <= i_run;
            if (!i_run) begin
                // Idle line toggles so no stale bit can pass for data
                o_rx_bit <= ~o_rx_bit;
            end else if (i_loop) begin
                o_rx_bit <= i_loop_bit ^ i_flip;
            end else begin
                // History keeps the true bit, so a flip costs one error only
                hist     <= {hist[18:0], nb};
                o_rx_bit <= nb ^ i_flip;
            end
        end
    end
endmodule : bertm_far_end
`default_nettype wire

// ==== test/bertm_monitor_tb.sv ====
// Self-checking bench for the BER monitor and transmit test modes
`timescale 1ns/10ps
`default_nettype none
module bertm_monitor_tb;
    import bertm_pkg::*;
    typedef struct {int c; logic [31:0] v;} bertm_note_type;
    logic           clk, rst, en, tde, sym, cw_m, alt_m, wide_m, run, loop, rxb, rxe, v;
    logic [7:0]     pls;
    logic [3:0]     psel;
    logic [15:0]    al, ar, bl, br, loss, tl, tr, rl, rr;
    logic [31:0]    el, err, bits, ratio, rnd;
    logic           lock, mb, cw, span, inh, txa, rxa;
    int             mismatches, samples_checked;
    bertm_note_type q[$];

    bertm_monitor #(.P_TICK_CYCLES(10), .P_TONE_HALF(8)) u_dut (
        .i_ref_clk(clk), .i_rst(rst), .i_bert_enable(en), .i_restart(pls[0]),
        .i_inject(pls[1]), .i_pattern_load(pls[2]), .i_pattern_sel(psel),
        .i_rx_bit(rxb), .i_rx_bit_en(rxe), .i_tx_data(al[0]), .i_tx_data_en(tde),
        .i_sym_en(sym), .i_carrier_mode(cw_m), .i_alt_mode(alt_m), .i_wide_mode(wide_m),
        .i_tx_tone_on(pls[3]), .i_tx_tone_off(pls[4]), .i_rx_tone_on(pls[5]),
        .i_rx_tone_off(pls[6]), .i_tx_aud_l(al), .i_tx_aud_r(ar), .i_rx_aud_l(bl),
        .i_rx_aud_r(br), .o_sync_lock(lock), .o_elapsed_ms(el), .o_loss_count(loss),
        .o_error_count(err), .o_bit_count(bits), .o_ber_ratio(ratio), .o_mod_bit(mb),
        .o_unmodulated_carrier_mode(cw), .o_demod_span_x4(span),
        .o_demod_lock_inhibit(inh), .o_tx_tone_active(txa), .o_rx_tone_active(rxa),
        .o_tx_aud_l(tl), .o_tx_aud_r(tr), .o_rx_aud_l(rl), .o_rx_aud_r(rr));
    bertm_far_end u_far (.i_ref_clk(clk), .i_rst(rst), .i_run(run), .i_loop(loop),
        .i_flip(pls[7]), .i_loop_bit(mb), .o_rx_bit(rxb), .o_rx_bit_en(rxe));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [31:0] obs(input int c);
        logic [31:0] t [0:14];
        t = '{{31'h0, lock}, el, {16'h0, loss}, err, bits, ratio, {31'h0, mb},
              {31'h0, cw}, {31'h0, span}, {31'h0, inh}, {30'h0, txa, rxa}, {tl, tr},
              {rl, rr}, {31'h0, (tl == tr) && (tl == 16'h4000 || tl == 16'hc000)},
              {31'h0, (rl == rr) && (rl == 16'h4000 || rl == 16'hc000)}};
        return t[c];
    endfunction : obs

    task automatic chk(input int c, input logic [31:0] x);
        q.push_back('{c, x});
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic pulse(input int w);
        @(posedge clk);
        pls[w] <= 1'b1;
        @(posedge clk);
        pls <= 8'h00;
        #1;
    endtask : pulse

    task automatic close_out();
        // Let the checker drain the last notes before the counts are read
        @(negedge clk);
        #1;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic wait_lock(input logic x);
        int n;
        n = 0;
        while (lock !== x && n < 400) begin
            tick(1);
            n++;
        end
        if (n >= 400) begin
            $display("MISMATCH %0t lock wait ran out", $time);
            mismatches++;
            close_out();
        end
    endtask : wait_lock

    always @(negedge clk) begin
        bertm_note_type e;
        while (q.size() > 0) begin
            e = q.pop_front();
            samples_checked++;
            if (obs(e.c) !== e.v) begin
                $display("MISMATCH %0t item %0d got %h want %h", $time, e.c, obs(e.c), e.v);
                mismatches++;
            end
        end
    end

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        rst = 1'b1;
        {en, tde, sym, cw_m, alt_m, wide_m, run, loop, pls, v} = '0;
        psel = 4'h3;
        rnd = 32'h8e92;
        {al, ar, bl, br} = {rnd, ~rnd};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        tick(2);
        for (int i = 7; i <= 10; i++) chk(i, 0);
        chk(0, 0);
        @(posedge clk);
        en <= 1'b1;
        run <= 1'b1;
        wait_lock(1'b1);
        chk(0, 1);
        pulse(7);
        tick(4);
        chk(3, 1);
        @(posedge clk);
        run <= 1'b0;
        tick(80);
        chk(5, 32'({32'h1, 32'h0} / {32'h0, bits}));
        @(posedge clk);
        run <= 1'b1;
        pls[7] <= 1'b1;
        repeat (20) @(posedge clk);
        pls[7] <= 1'b0;
        wait_lock(1'b0);
        tick(2);
        chk(2, 1);
        pulse(0);
        tick(1);
        for (int i = 0; i <= 5; i++) chk(i, 0);
        tick(24);
        chk(1, 2);
        $display("test checker done");
        // Loopback lets the checker judge the generator's own pattern
        @(posedge clk);
        loop <= 1'b1;
        tde <= 1'b1;
        pulse(0);
        wait_lock(1'b1);
        chk(3, 0);
        pulse(1);
        tick(8);
        chk(3, 1);
        chk(0, 1);
        for (int p = 0; p < 10; p++) begin
            @(posedge clk);
            psel <= 4'(p);
            pulse(2);
            pulse(0);
            wait_lock(1'b1);
            chk(0, 1);
        end
        $display("test generator done");
        @(posedge clk);
        cw_m <= 1'b1;
        tick(3);
        chk(7, 1);
        chk(6, 0);
        @(posedge clk);
        cw_m <= 1'b0;
        alt_m <= 1'b1;
        tick(3);
        for (int i = 0; i < 4; i++) begin
            v = mb;
            @(posedge clk);
            sym <= 1'b1;
            @(posedge clk);
            sym <= 1'b0;
            tick(1);
            chk(6, {31'h0, ~v});
        end
        @(posedge clk);
        wide_m <= 1'b1;
        rnd = lfsr(rnd);
        {al, ar, bl, br} <= {rnd, ~rnd};
        tick(3);
        chk(8, 1);
        chk(9, 1);
        pulse(3);
        tick(3);
        chk(10, 2);
        chk(13, 1);
        chk(12, {bl, br});
        pulse(5);
        pulse(4);
        tick(3);
        chk(10, 1);
        chk(11, {al, ar});
        chk(14, 1);
        pulse(6);
        tick(3);
        chk(10, 0);
        $display("test modes done");
        close_out();
    end
endmodule : bertm_monitor_tb
`default_nettype wire
